// File: dv/host_word_writer.sv
`timescale 1ns/1ns
`default_nettype none
module host_word_writer
(
    // clock
    input wire logic mclk,
    // parallel 16-bit word port with strobe
    output logic [15:0] word_data,
    output logic word_strobe
);
    initial
    begin
        word_data = 16'h0000;
        word_strobe = 1'b0;
    end
    task automatic put(input logic [15:0] w);
        @(posedge mclk) #1;
        word_data = w;
        word_strobe = 1'b1;
        @(posedge mclk) #1;
        word_strobe = 1'b0;
        // released data must not look like the last word
        word_data = ~w;
    endtask
    task automatic write_ctl(input logic [13:0] f);
        logic [15:0] w;
        w = {2'b00, f};
        w = w & 16'hFFFA;
        if (w[5])
        begin
            w[1] = 1'b0;
        end
        put(w);
    endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench
    import dds_ctrl_pkg::*;
;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] word_data;
    logic word_strobe;
    logic fpin = 1'b0, ppin = 1'b0, rpin = 1'b0, dpin = 1'b0, cmp = 1'b0;
    logic [ACC_W-1:0] freq_a = 28'h0400000;
    logic [ACC_W-1:0] freq_b = 28'h0800000;
    logic [PH_W-1:0] pha = 12'h000;
    logic [PH_W-1:0] phb = 12'h800;
    logic [DAC_W-1:0] dac;
    logic [DAC_W-1:0] held;
    logic pd, sq, oe_n, fs, ps, dr;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    always #10 mclk = ~mclk;
    host_word_writer host_word_writer_i (.mclk(mclk), .word_data(word_data), .word_strobe(word_strobe));
    dds_control_word_decode dds_control_word_decode_i (
        .mclk(mclk), .arst_n(arst_n), .word_data(word_data), .word_strobe(word_strobe),
        .freq_word_a(freq_a), .freq_word_b(freq_b),
        .phase_offset_reg_a(pha), .phase_offset_reg_b(phb),
        .freq_select_pin(fpin), .phase_select_pin(ppin), .reset_pin(rpin),
        .power_down_pin(dpin), .comparator_in(cmp), .dac_data(dac), .converter_power_down(pd),
        .square_pin_out(sq), .square_pin_oe_n(oe_n), .freq_select(fs), .phase_select(ps),
        .datapath_reset(dr));
    task automatic print_verdict();
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            print_verdict();
        end
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic ctl(input logic [13:0] f);
        host_word_writer_i.write_ctl(f);
        wait_n(2);
    endtask
    task automatic t_select();
        ctl(14'h0C00);
        `CHK("fsel", 1'b1, fs)
        `CHK("psel", 1'b1, ps)
        ctl(14'h0000);
        `CHK("psel0", 1'b0, ps)
    endtask
    task automatic t_power();
        ctl(14'h0040);
        `CHK("pd", 1'b1, pd)
        // a word with a frequency address must leave the control fields alone
        host_word_writer_i.put(16'h4000);
        wait_n(2);
        `CHK("pd_kept", 1'b1, pd)
        ctl(14'h0000);
        `CHK("pd0", 1'b0, pd)
    endtask
    task automatic t_gate();
        ctl(14'h0080);
        held = dac;
        wait_n(5);
        `CHK("gate", held, dac)
        ctl(14'h0000);
    endtask
    task automatic t_reset();
        host_word_writer_i.write_ctl(14'h0100);
        wait_n(2);
        `CHK("rst", 1'b1, dr)
        `CHK("mid", MID_SCALE, dac)
        host_word_writer_i.write_ctl(14'h0000);
        wait_n(6);
        `CHK("mid_hold", MID_SCALE, dac)
        wait_n(1);
        `CHK("run", 1'b1, dac !== MID_SCALE)
    endtask
    task automatic t_pins();
        ctl(14'h0200);
        fpin = 1'b1;
        ppin = 1'b1;
        rpin = 1'b1;
        dpin = 1'b1;
        wait_n(4);
        `CHK("pin_psel", 1'b1, ps)
        `CHK("pin_fsel", 1'b1, fs)
        `CHK("pin_rst", 1'b1, dr)
        `CHK("pin_pd", 1'b1, pd)
        ctl(14'h0000);
        `CHK("sw_rst", 1'b0, dr)
        fpin = 1'b0;
        ppin = 1'b0;
        rpin = 1'b0;
        dpin = 1'b0;
    endtask
    task automatic t_square();
        ctl(14'h0030);
        cmp = 1'b1;
        wait_n(4);
        `CHK("oe_on", 1'b0, oe_n)
        `CHK("cmp1", 1'b1, sq)
        cmp = 1'b0;
        wait_n(4);
        `CHK("cmp0", 1'b0, sq)
        ctl(14'h0000);
        `CHK("oe_off", 1'b1, oe_n)
    endtask
    task automatic t_phase();
        // a zero step freezes the phase, so only the offset moves the output
        freq_a = 28'h0000000;
        wait_n(10);
        held = dac;
        ctl(14'h0400);
        wait_n(8);
        `CHK("psel_shift", 1'b1, dac !== held)
        ctl(14'h0000);
        wait_n(8);
        `CHK("psel_back", held, dac)
        freq_a = 28'h0400000;
    endtask
    // one output period is 64 cycles, so 256 sampled cycles hold a whole number of periods
    task automatic count_sq(output int rises);
        logic last;
        rises = 0;
        wait_n(8);
        last = sq;
        repeat (256)
        begin
            wait_n(1);
            if (sq && !last)
                rises++;
            last = sq;
        end
    endtask
    task automatic t_halve();
        int rises;
        ctl(14'h0028);
        count_sq(rises);
        `CHK("direct_rises", 4, rises)
        ctl(14'h0020);
        count_sq(rises);
        `CHK("halved_rises", 2, rises)
        ctl(14'h0000);
    endtask
    // a full up and down sweep of the converter in 64 cycles moves it by 32 codes a cycle
    task automatic count_lin(output int lin);
        logic [DAC_W-1:0] last;
        int d;
        lin = 0;
        wait_n(8);
        last = dac;
        repeat (64)
        begin
            wait_n(1);
            d = int'(dac) - int'(last);
            if (d == 32 || d == -32)
                lin++;
            last = dac;
        end
    endtask
    task automatic t_wave();
        int lin;
        ctl(14'h0002);
        count_lin(lin);
        `CHK("ramp_lin", 1'b1, lin >= 60)
        ctl(14'h0000);
        count_lin(lin);
        `CHK("sine_curve", 1'b1, lin < 60)
    endtask
    initial
    begin
        repeat (10) @(posedge mclk);
        #1;
        `CHK("oe_rst", 1'b1, oe_n)
        arst_n = 1'b1;
        wait_n(2);
        t_select();
        t_phase();
        t_power();
        t_gate();
        t_reset();
        t_pins();
        t_square();
        t_halve();
        t_wave();
        print_verdict();
    end
endmodule
`default_nettype wire

// File: src/dds_control_word_decode.sv
// Overview of operation
// R1 - phase select picks offset register added
// R2 - source 1: select, reset, powerdown from pins
// R3 - source 0: those functions from control fields
// R4 - reset clears datapath, output goes midscale
// R5 - clock gate halts accumulator, output holds
// R6 - power-down field switches converter off
// R7 - enable drives square pin, else high-Z
// R8 - host keeps enable 0 when unused
// R9 - source 1 routes comparator to pin
// R10 - source 0 routes data MSB to pin
// R11 - halving select 1 direct, 0 halved
// R12 - host writes zero to reserved bits
// R13 - waveform 1 bypasses sine table: ramp
// R14 - waveform 0 uses sine table
// R15 - host clears waveform when enable set
// R16 - fields except waveform sampled falling edge
// R17 - top two bits zero mark control write
// R18 - output signal seven cycles after release
`timescale 1ns/1ns
`default_nettype none
module dds_control_word_decode
    import dds_ctrl_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // control word writes
    input wire logic [15:0] word_data,
    input wire logic word_strobe,
    // frequency and phase registers held outside
    input wire logic [ACC_W-1:0] freq_word_a,
    input wire logic [ACC_W-1:0] freq_word_b,
    input wire logic [PH_W-1:0] phase_offset_reg_a,
    input wire logic [PH_W-1:0] phase_offset_reg_b,
    // external control pins
    input wire logic freq_select_pin,
    input wire logic phase_select_pin,
    input wire logic reset_pin,
    input wire logic power_down_pin,
    input wire logic comparator_in,
    // converter and square pin
    output logic [DAC_W-1:0] dac_data,
    output logic converter_power_down,
    output logic square_pin_out,
    output logic square_pin_oe_n,
    // decoded state
    output logic freq_select,
    output logic phase_select,
    output logic datapath_reset
);
    core_t cur;
    core_t next_cur;
    fall_t fall;

    // quarter sine, amplitude 0..511 at bin centres
    function automatic logic [8:0] quarter_sine(input logic [3:0] idx);
        logic [8:0] v;
        v = 9'h000;
        case (idx)
            4'h0: v = 9'h019;
            4'h1: v = 9'h04B;
            4'h2: v = 9'h07C;
            4'h3: v = 9'h0AC;
            4'h4: v = 9'h0DB;
            4'h5: v = 9'h107;
            4'h6: v = 9'h131;
            4'h7: v = 9'h157;
            4'h8: v = 9'h17B;
            4'h9: v = 9'h19B;
            4'hA: v = 9'h1B8;
            4'hB: v = 9'h1D0;
            4'hC: v = 9'h1E4;
            4'hD: v = 9'h1F3;
            4'hE: v = 9'h1FD;
            4'hF: v = 9'h1FF;
            default: v = 9'h000;
        endcase
        return v;
    endfunction

    logic [PH_W-1:0] phase;
    logic [3:0] sidx;
    logic [8:0] amp;
    logic [DAC_W-1:0] sample;
    logic digital_bit;

    always_comb
    begin
        next_cur = cur;
        next_cur.sync1 = {comparator_in, power_down_pin, reset_pin, phase_select_pin, freq_select_pin};
        next_cur.sync2 = cur.sync1;
        if (word_strobe && word_data[ADDR_HI:ADDR_LO] == CTL_ADDR)
        begin
            next_cur.ctl = word_data[CTL_W-1:0];
        end
        // phase offset lands on the top bits of the accumulator
        phase = cur.acc[ACC_W-1 -: PH_W] + (fall.psel ? phase_offset_reg_b : phase_offset_reg_a); // [R1]
        sidx = phase[PH_W-2] ? ~phase[PH_W-3 -: 4] : phase[PH_W-3 -: 4];
        amp = quarter_sine(sidx);
        if (cur.ctl[F_MODE])
        begin
            // waveform is read straight from the rising-edge copy
            sample = phase[PH_W-1] ? ~phase[PH_W-2 -: DAC_W] : phase[PH_W-2 -: DAC_W]; // [R13]
        end
        else if (phase[PH_W-1])
        begin
            sample = MID_LOW - DAC_W'(amp); // [R14]
        end
        else
        begin
            sample = MID_SCALE + DAC_W'(amp); // [R14]
        end
        if (fall.rst)
        begin
            next_cur.acc = '0; // [R4]
            next_cur.pipe = {PIPE_N{MID_SCALE}}; // [R4]
        end
        else if (!fall.gate) // [R5]
        begin
            next_cur.acc = cur.acc + (fall.fsel ? freq_word_b : freq_word_a);
            next_cur.pipe = {cur.pipe[PIPE_N-2:0], sample}; // [R18]
        end
        // halver toggles on each rising edge of the data MSB
        next_cur.msb_prev = cur.pipe[PIPE_N-1][DAC_W-1];
        if (cur.pipe[PIPE_N-1][DAC_W-1] && !cur.msb_prev)
        begin
            next_cur.half_tog = !cur.half_tog; // [R11]
        end
        digital_bit = fall.halve ? cur.pipe[PIPE_N-1][DAC_W-1] : cur.half_tog; // [R10] [R11]
        next_cur.square_out = fall.pin_src ? cur.sync2[P_CMP] : digital_bit; // [R9] [R10]
        next_cur.oe_n = !fall.pin_en; // [R7]
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // edge detector starts at the midscale MSB, so release shows no false rising edge
            cur <= '{ctl: CTL_RESET, pipe: {PIPE_N{MID_SCALE}}, msb_prev: MID_SCALE[DAC_W-1], oe_n: 1'b1, default: '0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // control fields other than the waveform are taken on the falling edge, so a half-cycle of setup is allowed
    always_ff @(negedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fall <= '{rst: 1'b1, default: '0};
        end
        else
        begin
            fall.psel <= cur.ctl[F_SRC] ? cur.sync2[P_PSEL] : cur.ctl[F_PSEL]; // [R2] [R3] [R16]
            fall.fsel <= cur.ctl[F_SRC] ? cur.sync2[P_FSEL] : cur.ctl[F_FSEL]; // [R2] [R3] [R16]
            fall.rst <= cur.ctl[F_SRC] ? cur.sync2[P_RST] : cur.ctl[F_RST]; // [R2] [R3] [R16]
            fall.pd <= cur.ctl[F_SRC] ? cur.sync2[P_PD] : cur.ctl[F_PD]; // [R2] [R3] [R6] [R16]
            fall.gate <= cur.ctl[F_GATE]; // [R16]
            fall.pin_en <= cur.ctl[F_PIN_EN]; // [R16]
            fall.pin_src <= cur.ctl[F_PIN_SRC]; // [R16]
            fall.halve <= cur.ctl[F_HALVE]; // [R16]
        end
    end

    assign dac_data = cur.pipe[PIPE_N-1];
    assign square_pin_out = cur.square_out;
    assign square_pin_oe_n = cur.oe_n;
    assign converter_power_down = fall.pd;
    assign freq_select = fall.fsel;
    assign phase_select = fall.psel;
    assign datapath_reset = fall.rst;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_reset_pulse;
        datapath_reset;
    endsequence
    sequence s_run_seven;
        (!datapath_reset && !fall.gate) [*7];
    endsequence

    a_reset_mid_scale: assert property (datapath_reset |=> dac_data == MID_SCALE) // [R4]
        else $error("reset did not force midscale");
    a_release_latency_hold: assert property (s_reset_pulse ##1 s_run_seven |-> dac_data == MID_SCALE) // [R18]
        else $error("converter left midscale too early after release");
    a_release_latency_show: assert property (
        s_reset_pulse ##1 (s_run_seven ##1 (!datapath_reset && !cur.ctl[F_MODE])) |-> dac_data != MID_SCALE) // [R18]
        else $error("no signal seven cycles after release");
    a_gate_holds_output: assert property (fall.gate && !datapath_reset |=> $stable(dac_data)) // [R5]
        else $error("output moved while clock gated");
    a_power_down_field: assert property (
        (!cur.ctl[F_SRC] && $stable(cur.ctl)) [*2] |-> converter_power_down == cur.ctl[F_PD]) // [R6]
        else $error("power-down does not follow field");
    a_pin_phase_select: assert property (
        (cur.ctl[F_SRC] && $stable(cur.sync2[P_PSEL])) [*2] |-> phase_select == cur.sync2[P_PSEL]) // [R2]
        else $error("phase select does not follow pin");
    a_enable_drives_pin: assert property (fall.pin_en |=> !square_pin_oe_n) // [R7]
        else $error("square pin not driven while enabled");
    a_comparator_route: assert property (fall.pin_src |=> square_pin_out == $past(cur.sync2[P_CMP])) // [R9]
        else $error("comparator not routed to square pin");
    a_msb_direct: assert property (!fall.pin_src && fall.halve |=> square_pin_out == $past(dac_data[DAC_W-1])) // [R10]
        else $error("data MSB not routed to square pin");
    a_disable_floats_pin: assert property (!fall.pin_en |=> square_pin_oe_n) // [R7]
        else $error("square pin driven while disabled");

    // halving path: the toggle flop flips once per rising edge of the data MSB
    a_halver_toggle: assert property (dac_data[DAC_W-1] && !cur.msb_prev |=> cur.half_tog != $past(cur.half_tog)) // [R11]
        else $error("halver missed a rising edge of the data MSB");
    a_halved_output: assert property (!fall.pin_src && !fall.halve |=> square_pin_out == $past(cur.half_tog)) // [R11]
        else $error("halved MSB not routed to square pin");
    a_pin_reset: assert property (
        (cur.ctl[F_SRC] && $stable(cur.sync2[P_RST])) [*2] |-> datapath_reset == cur.sync2[P_RST]) // [R2]
        else $error("datapath reset does not follow pin");
    a_field_select: assert property (
        (!cur.ctl[F_SRC] && $stable(cur.ctl)) [*2] |-> phase_select == cur.ctl[F_PSEL] && freq_select == cur.ctl[F_FSEL]) // [R3]
        else $error("selects do not follow control fields");
endmodule
`default_nettype wire

// File: src/dds_ctrl_pkg.sv
package dds_ctrl_pkg;
    localparam int CTL_W = 14;
    localparam logic [1:0] CTL_ADDR = 2'h0;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 14;
    // field positions inside oscillator_control_word
    localparam int F_FSEL = 11;
    localparam int F_PSEL = 10;
    localparam int F_SRC = 9;
    localparam int F_RST = 8;
    localparam int F_GATE = 7;
    localparam int F_PD = 6;
    localparam int F_PIN_EN = 5;
    localparam int F_PIN_SRC = 4;
    localparam int F_HALVE = 3;
    localparam int F_MODE = 1;
    localparam logic [CTL_W-1:0] CTL_RESET = 14'h0000;
    localparam int ACC_W = 28;
    localparam int PH_W = 12;
    localparam int DAC_W = 10;
    localparam logic [DAC_W-1:0] MID_SCALE = 10'h200;
    localparam logic [DAC_W-1:0] MID_LOW = 10'h1FF;
    localparam int PIPE_N = 7;
    localparam int PIN_N = 5;
    // synchronised pin slots
    localparam int P_FSEL = 0;
    localparam int P_PSEL = 1;
    localparam int P_RST = 2;
    localparam int P_PD = 3;
    localparam int P_CMP = 4;

    typedef struct packed {
        logic [CTL_W-1:0] ctl;
        logic [PIN_N-1:0] sync1;
        logic [PIN_N-1:0] sync2;
        logic [ACC_W-1:0] acc;
        logic [PIPE_N-1:0][DAC_W-1:0] pipe;
        logic msb_prev;
        logic half_tog;
        logic square_out;
        logic oe_n;
    } core_t;

    typedef struct packed {
        logic fsel;
        logic psel;
        logic rst;
        logic gate;
        logic pd;
        logic pin_en;
        logic pin_src;
        logic halve;
    } fall_t;
endpackage
